/* logic/rcrs_pkg.sv */
/*
  Package for the reset-cause and retention status block: register
  offsets, field positions, reset values and the event carrier struct.
  Assumes a 32-bit APB bus with each register on one aligned word.
*/
package rcrs_pkg;

  // ==========================================================================
  // Register offsets: deep sleep entries are register indices (byte address
  // is four times the index), the others are byte offsets
  // ==========================================================================
  localparam logic [11:0] RCRS_OFF_DSCTL   = 12'h10E; // Deep sleep control index
  localparam logic [11:0] RCRS_OFF_DEEP_SLEEP_WAKE_SOURCE  = 12'h110; // Deep sleep wake source index
  localparam logic [11:0] RCRS_OFF_DSSEM0  = 12'h112; // Semaphore 0 index
  localparam logic [11:0] RCRS_OFF_DSSEM1  = 12'h114; // Semaphore 1 index
  localparam logic [11:0] RCRS_OFF_PRIMARY = 12'h200; // Primary reset control
  localparam logic [11:0] RCRS_OFF_SECOND  = 12'h204; // Second reset control
  localparam logic [11:0] RCRS_OFF_IRQ_ST  = 12'h208; // Interrupt status
  localparam logic [11:0] RCRS_OFF_IRQ_MSK = 12'h20C; // Interrupt mask

  // ==========================================================================
  // Primary reset control field positions
  // ==========================================================================
  localparam int RCRS_P_TRAP   = 15;
  localparam int RCRS_P_ILLOP  = 14;
  localparam int RCRS_P_RETENTION_ENABLE  = 12;
  localparam int RCRS_P_DEEP_SLEEP_FLAG  = 10;
  localparam int RCRS_P_CFGMM  = 9;
  localparam int RCRS_P_PIN    = 7;
  localparam int RCRS_P_SWRST  = 6;
  localparam int RCRS_P_WATCHDOG_TIMEOUT_FLAG   = 4;
  localparam int RCRS_P_SLEEP  = 3;
  localparam int RCRS_P_IDLE   = 2;
  localparam int RCRS_P_BOR    = 1;
  localparam int RCRS_P_POR    = 0;
  localparam int RCRS_P_DEEP_SLEEP_ENABLE   = 15; // In deep sleep control

  // Second reset control fields and implemented masks of second, deep sleep control and wake source
  localparam int RCRS_S_BOR    = 3;
  localparam int RCRS_S_POR    = 2;
  localparam int RCRS_S_BPOR   = 1;
  localparam int RCRS_S_BAT    = 0;
  localparam logic [15:0] RCRS_SECOND_MASK = 16'h000F;
  localparam logic [15:0] RCRS_DSCTL_MASK  = 16'h8003;
  localparam logic [15:0] RCRS_DEEP_SLEEP_WAKE_SOURCE_MASK = 16'h019C;

  // Reset values
  localparam logic [15:0] RCRS_PRIMARY_RST = 16'h0003;
  localparam logic [15:0] RCRS_SECOND_RST  = 16'h000E;
  localparam logic [15:0] RCRS_ZERO16      = 16'h0000;

  // Interrupt status bits
  localparam int RCRS_IRQ_W    = 4;
  localparam int RCRS_I_WATCHDOG_TIMEOUT_FLAG   = 0;
  localparam int RCRS_I_ILLOP  = 1;
  localparam int RCRS_I_SLEEP  = 2;
  localparam int RCRS_I_BOR    = 3;

  // Power-save operands
  localparam logic RCRS_PS_SLEEP = 1'b0;
  localparam logic RCRS_PS_IDLE  = 1'b1;

  // Events from the core and supply monitors
  typedef struct packed {
    logic trap_conflict;
    logic illegal_op;
    logic config_mismatch;
    logic pin_reset;
    logic software_reset;
    logic watchdog_expiry;
    logic watchdog_clear_instruction;
    logic power_save_instruction;
    logic power_save_operand;
    logic brownout;
    logic core_poweron;
    logic backup_exit;
  } rcrs_event_t;

  // Wake events captured into the wake-source register
  typedef struct packed {
    logic ext_int;
    logic fault;
    logic watchdog;
    logic clock_alarm;
    logic pin_reset;
  } rcrs_wake_t;

endpackage

/* logic/rcrs_retain.sv */
/*
  Deep sleep retained registers: control, wake source and two semaphore
  words. Cleared only by the main-supply power-on reset input; assumes
  that domain stays powered from the backup supply pin.
*/
`timescale 1ns/1ps
module rcrs_retain
  import rcrs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        main_por_n,    // Main-supply power-on reset, low active
  input  wire logic        wr_ctl,        // Write strobe, control
  input  wire logic        wr_wake,       // Write strobe, wake source
  input  wire logic        wr_sem0,       // Write strobe, semaphore 0
  input  wire logic        wr_sem1,       // Write strobe, semaphore 1
  input  wire logic [15:0] wdata,         // Write data
  input  wire rcrs_wake_t  wake,          // Wake events
  input  wire logic        ds_brownout,   // Brown-out seen in deep sleep
  output logic      [15:0] ctl_reg,       // Deep sleep control
  output logic      [15:0] wake_reg,      // Wake source
  output logic      [15:0] sem0_reg,      // Semaphore 0
  output logic      [15:0] sem1_reg       // Semaphore 1
);

  // ==========================================================================
  // Control: enable writable, brown-out flag sticky
  // ==========================================================================
  always_ff @(posedge pclk or negedge main_por_n) begin
    if (!main_por_n) begin
      ctl_reg <= RCRS_ZERO16; // R8
    end else begin
      if (wr_ctl) begin
        ctl_reg <= wdata & RCRS_DSCTL_MASK;
      end
      // Set wins over a software clear in the same cycle
      if (ds_brownout) begin
        ctl_reg[1] <= 1'b1;
      end
    end
  end

  // Wake source, event set wins
  always_ff @(posedge pclk or negedge main_por_n) begin
    if (!main_por_n) begin
      wake_reg <= RCRS_ZERO16; // R8
    end else begin
      wake_reg <= ((wr_wake ? wdata : wake_reg) & RCRS_DEEP_SLEEP_WAKE_SOURCE_MASK)
                | {7'h00, wake.ext_int, wake.fault, 2'b00, wake.watchdog,
                   wake.clock_alarm, wake.pin_reset, 2'b00};
    end
  end

  // Semaphores survive every reset but main power-on
  always_ff @(posedge pclk or negedge main_por_n) begin
    if (!main_por_n) begin
      sem0_reg <= RCRS_ZERO16; // R8 R9
      sem1_reg <= RCRS_ZERO16;
    end else begin
      if (wr_sem0) begin
        sem0_reg <= wdata;
      end
      if (wr_sem1) begin
        sem1_reg <= wdata;
      end
    end
  end

endmodule

/* logic/rcrs_top.sv */
/*
  Reset-cause and retention status block: primary and second reset
  control flags, deep sleep retained registers, retention regulator
  enable and a masked interrupt. Assumes an APB master on pclk, event
  inputs that are one-cycle pulses synchronous to pclk, and a separate
  main-supply power-on reset for the retained registers.
*/
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// Operation
// R1: Main-supply power-on sets second-register power flag
// R2: Core power-on sets primary power-on bit
// R3: Backup power-on flag set at first power-up
// R4: Software may set or clear primary cause flags
// R5: Illegal operation flag set, cleared by power-on
// R6: Watchdog flag cleared by clear, power-save, power-on
// R7: Power-save operand selects sleep, deep, idle flag
// R8: Deep sleep registers zeroed only by main power-on
// R9: Semaphores retained on backup supply
// R10: Retention regulator only during sleep
// R11: Retention needs config bit zero and enable
// R12: Retention powers memory and watchdog in sleep
// R13: Watchdog counter cleared before entering sleep
// R14: Second-register flags cleared by writing zero
// R15: Unimplemented second-register bits read zero
module rcrs_top
  import rcrs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        main_por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire rcrs_event_t evt,
  input  wire rcrs_wake_t  wake,
  input  wire logic        main_supply_brownout,
  input  wire logic        deep_sleep_brownout,
  input  wire logic        wake_event,
  input  wire logic        config_low_power_bit,
  input  wire logic        watchdog_enabled,
  output logic             retention_regulator_on,
  output logic             retention_domain_keep,
  output logic             watchdog_counter_clear,
  output logic             sleep_active,
  output logic             irq
);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  // Word-aligned match against a byte offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  // Deep sleep registers are given by index; each index owns one 32-bit word,
  // so neighbouring halfword-spaced indices never share a word
  function automatic logic ds_hit(input logic [11:0] a, input logic [11:0] idx);
    ds_hit = (a[11:2] == idx[9:0]);
  endfunction

  logic        acc;         // Access phase of a write
  logic        rd_acc;      // Access phase of a read
  logic [15:0] wd;          // Low halfword of write data
  logic        lo_en;       // Low lanes written
  assign acc    = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign wd     = pwdata[15:0];
  assign lo_en  = pstrb[0] && pstrb[1];
  assign pready = 1'b1;     // Zero wait states

  // Write strobes, one per register
  logic wr_ctl;
  logic wr_wake;
  logic wr_sem0;
  logic wr_sem1;
  logic wr_pri;
  logic wr_sec;
  logic wr_ist;
  logic wr_msk;
  logic known;
  assign wr_ctl  = acc && lo_en && ds_hit(paddr, RCRS_OFF_DSCTL);
  assign wr_wake = acc && lo_en && ds_hit(paddr, RCRS_OFF_DEEP_SLEEP_WAKE_SOURCE);
  assign wr_sem0 = acc && lo_en && ds_hit(paddr, RCRS_OFF_DSSEM0);
  assign wr_sem1 = acc && lo_en && ds_hit(paddr, RCRS_OFF_DSSEM1);
  assign wr_pri  = acc && lo_en && hit(paddr, RCRS_OFF_PRIMARY);
  assign wr_sec  = acc && lo_en && hit(paddr, RCRS_OFF_SECOND);
  assign wr_ist  = acc && lo_en && hit(paddr, RCRS_OFF_IRQ_ST);
  assign wr_msk  = acc && lo_en && hit(paddr, RCRS_OFF_IRQ_MSK);
  assign known   = ds_hit(paddr, RCRS_OFF_DSCTL) || ds_hit(paddr, RCRS_OFF_DEEP_SLEEP_WAKE_SOURCE)
                || ds_hit(paddr, RCRS_OFF_DSSEM0) || ds_hit(paddr, RCRS_OFF_DSSEM1)
                || hit(paddr, RCRS_OFF_PRIMARY) || hit(paddr, RCRS_OFF_SECOND)
                || hit(paddr, RCRS_OFF_IRQ_ST) || hit(paddr, RCRS_OFF_IRQ_MSK);

  // ==========================================================================
  // Retained deep sleep registers
  // ==========================================================================
  logic [15:0] ds_ctl;
  logic [15:0] ds_wake;
  logic [15:0] ds_sem0;
  logic [15:0] ds_sem1;

  rcrs_retain u_retain (
    .pclk        (pclk),
    .main_por_n  (main_por_n),
    .wr_ctl      (wr_ctl),
    .wr_wake     (wr_wake),
    .wr_sem0     (wr_sem0),
    .wr_sem1     (wr_sem1),
    .wdata       (wd),
    .wake        (wake),
    .ds_brownout (deep_sleep_brownout),
    .ctl_reg     (ds_ctl),
    .wake_reg    (ds_wake),
    .sem0_reg    (ds_sem0),
    .sem1_reg    (ds_sem1)
  );

  logic deep_sleep_enable;
  assign deep_sleep_enable = ds_ctl[RCRS_P_DEEP_SLEEP_ENABLE];

  // ==========================================================================
  // Primary reset control flags
  // ==========================================================================
  logic [15:0] primary_reg;
  logic        ps_sleep;    // Power-save with operand 0
  logic        ps_idle;     // Power-save with operand 1
  assign ps_sleep = evt.power_save_instruction && (evt.power_save_operand == RCRS_PS_SLEEP);
  assign ps_idle  = evt.power_save_instruction && (evt.power_save_operand == RCRS_PS_IDLE);

  // Power-on reset is the async reset, so every flag clears there and the
  // power-on and brown-out bits come back set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_reg <= RCRS_PRIMARY_RST; // R2
    end else begin
      // Software write first; hardware events then override
      if (wr_pri) begin
        primary_reg <= wd; // R4
      end
      if (evt.watchdog_clear_instruction || evt.power_save_instruction) begin
        primary_reg[RCRS_P_WATCHDOG_TIMEOUT_FLAG] <= 1'b0; // R6
      end
      if (evt.watchdog_expiry) begin
        primary_reg[RCRS_P_WATCHDOG_TIMEOUT_FLAG] <= 1'b1; // R6
      end
      if (evt.illegal_op) begin
        primary_reg[RCRS_P_ILLOP] <= 1'b1; // R5
      end
      if (evt.trap_conflict) begin
        primary_reg[RCRS_P_TRAP] <= 1'b1;
      end
      if (evt.config_mismatch) begin
        primary_reg[RCRS_P_CFGMM] <= 1'b1;
      end
      if (evt.pin_reset) begin
        primary_reg[RCRS_P_PIN] <= 1'b1;
      end
      if (evt.software_reset) begin
        primary_reg[RCRS_P_SWRST] <= 1'b1;
      end
      if (ps_sleep && deep_sleep_enable) begin
        primary_reg[RCRS_P_DEEP_SLEEP_FLAG] <= 1'b1; // R7
      end
      if (ps_sleep && !deep_sleep_enable) begin
        primary_reg[RCRS_P_SLEEP] <= 1'b1; // R7
      end
      if (ps_idle) begin
        primary_reg[RCRS_P_IDLE] <= 1'b1; // R7
      end
      if (main_supply_brownout) begin
        primary_reg[RCRS_P_BOR] <= 1'b1;
      end
      if (evt.core_poweron) begin
        primary_reg[RCRS_P_POR] <= 1'b1; // R2
        primary_reg[RCRS_P_BOR] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Second reset control flags: hardware set, software clear only
  // ==========================================================================
  logic [3:0] second_reg;
  logic [3:0] second_next;
  always_comb begin
    second_next = second_reg;
    if (wr_sec) begin
      second_next = second_reg & wd[3:0]; // R14
    end
    if (main_supply_brownout) begin
      second_next[RCRS_S_BOR] = 1'b1;
    end
    if (evt.backup_exit) begin
      second_next[RCRS_S_BAT] = 1'b1;
    end
  end

  // Main power-on reset brings supply and backup power-on flags up
  always_ff @(posedge pclk or negedge main_por_n) begin
    if (!main_por_n) begin
      second_reg <= RCRS_SECOND_RST[3:0]; // R1 R3
    end else begin
      second_reg <= second_next;
    end
  end

  // ==========================================================================
  // Sleep state and retention regulator
  // ==========================================================================
  // Sleep holds from power-save operand 0 until a wake or reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_active <= 1'b0;
    end else if (wake_event) begin
      sleep_active <= 1'b0;
    end else if (ps_sleep) begin
      sleep_active <= 1'b1;
    end
  end

  // Regulator only in sleep, never in run or idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retention_regulator_on <= 1'b0;
      retention_domain_keep  <= 1'b0;
    end else begin
      retention_regulator_on <= sleep_active && !wake_event && !config_low_power_bit
                             && primary_reg[RCRS_P_RETENTION_ENABLE]; // R10 R11
      retention_domain_keep  <= sleep_active && !wake_event; // R12
    end
  end

  // Registered pulse on the sleep entry edge, so the counter starts sleep
  // cleared before the watchdog clock is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_counter_clear <= 1'b0;
    end else begin
      watchdog_counter_clear <= ps_sleep && watchdog_enabled; // R13
    end
  end

  // ==========================================================================
  // Interrupt status and mask
  // ==========================================================================
  logic [RCRS_IRQ_W-1:0] irq_status_reg;
  logic [RCRS_IRQ_W-1:0] irq_mask_reg;
  logic [RCRS_IRQ_W-1:0] irq_set;
  assign irq_set = {main_supply_brownout, ps_sleep, evt.illegal_op, evt.watchdog_expiry};

  // Write one to clear; a new event in the same cycle stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~(wr_ist ? wd[RCRS_IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= '0;
    end else if (wr_msk) begin
      irq_mask_reg <= wd[RCRS_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ==========================================================================
  // Read data and error response
  // ==========================================================================
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = RCRS_ZERO16;
    if (ds_hit(paddr, RCRS_OFF_DSCTL)) begin
      rd_mux = ds_ctl;
    end else if (ds_hit(paddr, RCRS_OFF_DEEP_SLEEP_WAKE_SOURCE)) begin
      rd_mux = ds_wake;
    end else if (ds_hit(paddr, RCRS_OFF_DSSEM0)) begin
      rd_mux = ds_sem0;
    end else if (ds_hit(paddr, RCRS_OFF_DSSEM1)) begin
      rd_mux = ds_sem1;
    end else if (hit(paddr, RCRS_OFF_PRIMARY)) begin
      rd_mux = primary_reg;
    end else if (hit(paddr, RCRS_OFF_SECOND)) begin
      rd_mux = {12'h000, second_reg} & RCRS_SECOND_MASK; // R15
    end else if (hit(paddr, RCRS_OFF_IRQ_ST)) begin
      rd_mux = {12'h000, irq_status_reg};
    end else if (hit(paddr, RCRS_OFF_IRQ_MSK)) begin
      rd_mux = {12'h000, irq_mask_reg};
    end
  end

  assign prdata  = rd_acc ? {16'h0000, rd_mux} : 32'h0000_0000;
  assign pslverr = psel && penable && !known;

endmodule

/* verification/rcrs_asserts.sv */
/*
  Port checker for the reset-cause and retention block.
  Assumes it is bound to rcrs_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module rcrs_asserts
  import rcrs_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire rcrs_event_t evt,
  input wire logic        wake_event,
  input wire logic        config_low_power_bit,
  input wire logic        watchdog_enabled,
  input wire logic        retention_regulator_on,
  input wire logic        watchdog_counter_clear,
  input wire logic        sleep_active
);
  // One clock domain, core reset disables every check
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Bus answers
  // ==========================================================================
  bus_ready_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  bus_quiet_a: assert property (!(psel && penable) |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("bus outputs active outside access");
  upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");

  // ==========================================================================
  // Sleep entry and watchdog clear
  // ==========================================================================
  wd_clear_a: assert property (evt.power_save_instruction && !evt.power_save_operand
    && watchdog_enabled |=> watchdog_counter_clear)
    else $error("no watchdog clear on sleep entry");
  wd_cause_a: assert property (watchdog_counter_clear |->
    $past(evt.power_save_instruction && watchdog_enabled))
    else $error("watchdog clear without cause");
  sleep_entry_a: assert property (evt.power_save_instruction && !evt.power_save_operand
    && !wake_event |=> sleep_active)
    else $error("sleep not entered");
  idle_not_sleep_a: assert property (evt.power_save_instruction && evt.power_save_operand
    && !sleep_active |=> !sleep_active)
    else $error("idle entered sleep");

  // ==========================================================================
  // Retention regulator
  // ==========================================================================
  retention_enable_cfg_a: assert property (retention_regulator_on |-> !$past(config_low_power_bit))
    else $error("regulator on with config bit set");
  retention_enable_sleep_a: assert property (retention_regulator_on |-> $past(sleep_active))
    else $error("regulator on outside sleep");
  wake_off_a: assert property (wake_event |=> !retention_regulator_on)
    else $error("regulator on after wake");
endmodule

/* verification/tb.sv */
/*
  Self-checking bench for rcrs_top: APB register tasks, event pulses,
  sleep and retention scenarios and a watchdog on the whole run.
  Assumes the map and zero-wait bus given in the design hand-over.
*/
`timescale 1ns/1ps
module tb
  import rcrs_pkg::*;
;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        pclk, presetn, main_por_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_tmp;
  logic [3:0]  pstrb;
  rcrs_event_t evt, ev;
  rcrs_wake_t  wake;
  logic        wake_event, cfg_bit, wd_en, last_err, irq;
  logic        reg_on, keep_on, wd_clr, sleep_on, bor, ds_bor;
  int          err_count, checks_done;
  // Deep sleep registers: byte address is four times the register index
  localparam logic [11:0] DSCTL_A  = 12'h438;
  localparam logic [11:0] DEEP_SLEEP_WAKE_SOURCE_A = 12'h440;
  localparam logic [11:0] SEM0_A   = 12'h448;

  rcrs_top u_dut (.pclk(pclk), .presetn(presetn), .main_por_n(main_por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .evt(evt), .wake(wake),
    .main_supply_brownout(bor), .deep_sleep_brownout(ds_bor), .wake_event(wake_event),
    .config_low_power_bit(cfg_bit), .watchdog_enabled(wd_en),
    .retention_regulator_on(reg_on), .retention_domain_keep(keep_on),
    .watchdog_counter_clear(wd_clr), .sleep_active(sleep_on), .irq(irq));

  always #50 pclk = ~pclk;

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; waits for pready, a stall is caught by the run watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_tmp = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_tmp, e);
  endtask

  // Event pulses last exactly one cycle, as the block expects
  task automatic fire(input rcrs_event_t e);
    @(posedge pclk);
    evt <= e;
    @(posedge pclk);
    evt <= '0;
  endtask

  task automatic sleep_ev(input logic op);
    ev = '0;
    ev.power_save_instruction = 1'b1;
    ev.power_save_operand = op;
    fire(ev);
  endtask

  task automatic wake_up();
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    @(posedge pclk);
    #1;
    chk(sleep_on, 1'b0);
    chk(reg_on, 1'b0);
    chk(keep_on, 1'b0);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    rd(RCRS_OFF_PRIMARY, 32'h0000_0003);
    rd(RCRS_OFF_SECOND, 32'h0000_000E);
    rd(DSCTL_A, 32'h0000_0000);
    rd(SEM0_A, 32'h0000_0000);
  endtask

  // Every implemented cause bit set and cleared by software
  task automatic t_soft();
    apb(1'b1, RCRS_OFF_PRIMARY, 32'hFFFF_FFFF);
    rd(RCRS_OFF_PRIMARY, 32'h0000_FFFF);
    apb(1'b1, RCRS_OFF_PRIMARY, 32'h0000_0000);
    rd(RCRS_OFF_PRIMARY, 32'h0000_0000);
  endtask

  // Six hardware events, trap conflict to watchdog expiry, each land on their own cause bit
  task automatic t_events();
    int eb[6] = '{11, 10, 9, 8, 7, 6};
    int pb[6] = '{15, 14, 9, 7, 6, 4};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, RCRS_OFF_PRIMARY, 32'h0000_0000);
      fire(rcrs_event_t'(12'h001 << eb[i]));
      rd(RCRS_OFF_PRIMARY, 32'h0000_0001 << pb[i]);
    end
  endtask

  // Sticky status, mask gating and write-one-to-clear
  task automatic t_irq();
    rd(RCRS_OFF_IRQ_ST, 32'h0000_0003);
    chk(irq, 1'b0);
    apb(1'b1, RCRS_OFF_IRQ_MSK, 32'h0000_0002);
    #1 chk(irq, 1'b1);
    apb(1'b1, RCRS_OFF_IRQ_ST, 32'h0000_0002);
    #1 chk(irq, 1'b0);
    rd(RCRS_OFF_IRQ_ST, 32'h0000_0001);
    apb(1'b1, RCRS_OFF_IRQ_MSK, 32'h0000_0001);
    #1 chk(irq, 1'b1);
    apb(1'b1, RCRS_OFF_IRQ_ST, 32'h0000_0001);
    #1 chk(irq, 1'b0);
  endtask

  task automatic t_wdt();
    apb(1'b1, RCRS_OFF_PRIMARY, 32'h0000_0000);
    ev = '0;
    ev.watchdog_expiry = 1'b1;
    fire(ev);
    ev = '0;
    ev.watchdog_clear_instruction = 1'b1;
    fire(ev);
    rd(RCRS_OFF_PRIMARY, 32'h0000_0000);
    ev = '0;
    ev.watchdog_expiry = 1'b1;
    fire(ev);
    sleep_ev(RCRS_PS_IDLE);
    rd(RCRS_OFF_PRIMARY, 32'h0000_0004);
  endtask

  // Plain sleep with retention, then deep sleep with the config bit blocking it
  task automatic t_sleep();
    apb(1'b1, RCRS_OFF_PRIMARY, 32'h0000_1000);
    sleep_ev(RCRS_PS_SLEEP);
    #1 chk(wd_clr, 1'b1);
    @(posedge pclk);
    #1;
    chk(sleep_on, 1'b1);
    chk(reg_on, 1'b1);
    chk(keep_on, 1'b1);
    chk(wd_clr, 1'b0);
    rd(RCRS_OFF_PRIMARY, 32'h0000_1008);
    wake_up();
    apb(1'b1, DSCTL_A, 32'h0000_8000);
    apb(1'b1, RCRS_OFF_PRIMARY, 32'h0000_1000);
    cfg_bit <= 1'b1;
    wd_en <= 1'b0;
    sleep_ev(RCRS_PS_SLEEP);
    #1 chk(wd_clr, 1'b0);
    @(posedge pclk);
    #1;
    chk(reg_on, 1'b0);
    rd(RCRS_OFF_PRIMARY, 32'h0000_1400);
    wake_up();
    cfg_bit <= 1'b0;
    wd_en <= 1'b1;
  endtask

  // Retained words survive a core reset, only main power-on clears them
  task automatic t_retain();
    apb(1'b1, SEM0_A, 32'h0000_A5C3);
    apb(1'b1, DSCTL_A, 32'h0000_8001);
    @(posedge pclk);
    wake.ext_int <= 1'b1;
    @(posedge pclk);
    wake.ext_int <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(SEM0_A, 32'h0000_A5C3);
    rd(DSCTL_A, 32'h0000_8001);
    rd(DEEP_SLEEP_WAKE_SOURCE_A, 32'h0000_0100);
    rd(RCRS_OFF_PRIMARY, 32'h0000_0003);
    apb(1'b1, RCRS_OFF_SECOND, 32'h0000_000B);
    rd(RCRS_OFF_SECOND, 32'h0000_000A);
    apb(1'b1, RCRS_OFF_SECOND, 32'h0000_FFF0);
    rd(RCRS_OFF_SECOND, 32'h0000_0000);
    // Brown-outs and a backup-supply exit raise their flags again
    @(posedge pclk);
    {bor, ds_bor, evt.backup_exit} <= 3'b111;
    @(posedge pclk);
    {bor, ds_bor, evt.backup_exit} <= 3'b000;
    rd(RCRS_OFF_SECOND, 32'h0000_0009);
    rd(DSCTL_A, 32'h0000_8003);
    @(posedge pclk);
    presetn <= 1'b0;
    main_por_n <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    main_por_n <= 1'b1;
    rd(SEM0_A, 32'h0000_0000);
    rd(DSCTL_A, 32'h0000_0000);
    rd(RCRS_OFF_SECOND, 32'h0000_000E);
    apb(1'b0, 12'h3F0, 32'h0000_0000);
    chk(last_err, 1'b1);
  endtask

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic close_out();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    err_count++;
    $display("Error %0t: run timed out", $time);
    close_out();
  end

  initial begin
    {pclk, presetn, main_por_n, psel, penable, pwrite, wake_event, cfg_bit, bor, ds_bor} = '0;
    {paddr, pwdata, evt, wake, err_count, checks_done} = '0;
    pstrb = 4'hF;
    wd_en = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    main_por_n <= 1'b1;
    t_reset();
    t_soft();
    t_events();
    t_irq();
    t_wdt();
    t_sleep();
    t_retain();
    close_out();
  end
endmodule

bind rcrs_top rcrs_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .prdata, .pslverr, .evt, .wake_event, .config_low_power_bit, .watchdog_enabled,
  .retention_regulator_on, .watchdog_counter_clear, .sleep_active);
